// ===== hdl/rcfa_core.sv
`timescale 1ns/10ps
module rcfa_core (
  input  wire logic        CLK_IN,           // Core clock
  input  wire logic        RST_IN,           // Async reset, active high
  output logic      [9:0]  PMEM_ADDR_OUT,    // Fetch address
  input  wire logic [13:0] PMEM_DATA_IN,     // Word at fetch address
  output logic      [6:0]  DMEM_RD_ADDR_OUT, // Data read address
  input  wire logic [7:0]  DMEM_RDATA_IN,    // Byte at read address
  output logic      [6:0]  DMEM_WR_ADDR_OUT, // Data write address
  output logic      [7:0]  DMEM_WDATA_OUT,   // Data write byte
  output logic             DMEM_WE_OUT,      // Data write strobe
  output logic      [7:0]  W_OUT,            // Accumulator value
  output logic      [2:0]  FLAGS_OUT,        // Zero, half carry, carry
  output logic             EXEC_VALID_OUT    // Execute slot holds real work
);

  rcfa_pkg::rcfa_state_s cur;
  rcfa_pkg::rcfa_state_s nxt;

  logic [1:0] cls;
  logic [3:0] op;
  logic       dest_file;
  logic [7:0] lit;
  logic [9:0] exec_pc;
  logic [7:0] file_val;
  logic [7:0] dmem_val;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;
  logic       upd_c;
  logic       upd_dc;
  logic       upd_z;
  logic       fw_en;
  logic [7:0] fw_data;
  logic       branch;
  logic [9:0] branch_pc;

  // Addresses served by the core instead of data memory
  function automatic logic is_core_reg(input logic [6:0] a);
    return (a == rcfa_pkg::ADDR_INDIRECT) || (a == rcfa_pkg::ADDR_PCL) ||
           (a == rcfa_pkg::ADDR_STATUS) || (a == rcfa_pkg::ADDR_FSR);
  endfunction

  // Indirect slot resolves to the pointer's low seven bits
  function automatic logic [6:0] resolve(input logic [6:0] a,
                                         input logic [7:0] ptr);
    return (a == rcfa_pkg::ADDR_INDIRECT) ? ptr[6:0] : a;
  endfunction

  // Instruction fields of the word in the execute slot
  assign cls       = cur.ir[rcfa_pkg::CLS_HI:rcfa_pkg::CLS_LO];
  assign op        = cur.ir[rcfa_pkg::OP_HI:rcfa_pkg::OP_LO];
  assign dest_file = cur.ir[rcfa_pkg::DEST_B];
  assign lit       = cur.ir[7:0];
  assign exec_pc   = cur.pc - 10'h001;

  // Write lags one cycle, so a read of the same byte is forwarded
  assign dmem_val = (cur.wr_en && (cur.wr_addr == cur.rd_addr)) ?
                    cur.wr_data : DMEM_RDATA_IN;

  always_comb begin
    file_val = dmem_val;
    if (is_core_reg(cur.rd_addr)) begin
      case (cur.rd_addr)
        rcfa_pkg::ADDR_PCL:    file_val = exec_pc[7:0];
        rcfa_pkg::ADDR_STATUS: file_val = {5'h00, cur.flags};
        rcfa_pkg::ADDR_FSR:    file_val = cur.fsr;
        default:               file_val = 8'h00;
      endcase
    end
  end

  // second operand is file or literal
  assign alu_b = (cls == rcfa_pkg::CLS_LIT) ? lit : file_val;

  rcfa_alu u_alu (
    .op_in      (op),
    .lit_in     (cls == rcfa_pkg::CLS_LIT),
    .w_in       (cur.w),
    .b_in       (alu_b),
    .carry_in   (cur.flags[rcfa_pkg::ST_C]),
    .res_out    (alu_res),
    .c_out      (alu_c),
    .dc_out     (alu_dc),
    .z_out      (alu_z),
    .upd_c_out  (upd_c),
    .upd_dc_out (upd_dc),
    .upd_z_out  (upd_z)
  );

  // Execute the word in the slot and fetch the next one
  always_comb begin
    nxt       = cur;
    nxt.wr_en = 1'b0;
    nxt.pipe  = rcfa_pkg::PIPE_RUN;
    fw_en     = 1'b0;
    fw_data   = alu_res;
    branch    = 1'b0;
    branch_pc = cur.pc;
    case (cur.pipe)
      rcfa_pkg::PIPE_RUN: begin
        case (cls)
          rcfa_pkg::CLS_GOTO: begin
            branch    = 1'b1;
            branch_pc = cur.ir[9:0];
          end
          rcfa_pkg::CLS_LIT: begin
            if (op != rcfa_pkg::OP_NOP && op != rcfa_pkg::OP_RSVD) begin
              nxt.w = alu_res;
            end
          end
          rcfa_pkg::CLS_BYTE: begin
            if (op == rcfa_pkg::OP_MOVWF) begin
              fw_en = 1'b1;
            end else if (op != rcfa_pkg::OP_NOP &&
                         op != rcfa_pkg::OP_RSVD) begin
              if (dest_file) begin
                fw_en = 1'b1;
              end else begin
                nxt.w = alu_res;
              end
            end
          end
          default: ;
        endcase
      end
      rcfa_pkg::PIPE_FLUSH: ;
      default: ;
    endcase

    // every file address except 0 (indirect slot) takes a write
    if (fw_en) begin
      case (cur.rd_addr)
        rcfa_pkg::ADDR_STATUS: nxt.flags = fw_data[2:0];
        rcfa_pkg::ADDR_FSR:    nxt.fsr   = fw_data;
        // writing the PC low byte branches
        rcfa_pkg::ADDR_PCL: begin
          branch    = 1'b1;
          branch_pc = {exec_pc[9:8], fw_data};
        end
        rcfa_pkg::ADDR_INDIRECT: ;
        default: begin
          nxt.wr_en   = 1'b1;
          nxt.wr_addr = cur.rd_addr;
          nxt.wr_data = fw_data;
        end
      endcase
    end

    // flags after any status write
    // Reserved class and no-op codes must leave the flags untouched
    if (cur.pipe == rcfa_pkg::PIPE_RUN &&
        (cls == rcfa_pkg::CLS_BYTE || cls == rcfa_pkg::CLS_LIT) &&
        op != rcfa_pkg::OP_NOP && op != rcfa_pkg::OP_RSVD) begin
      if (upd_c) begin
        nxt.flags[rcfa_pkg::ST_C] = alu_c;
      end
      if (upd_dc) begin
        nxt.flags[rcfa_pkg::ST_DC] = alu_dc;
      end
      if (upd_z) begin
        nxt.flags[rcfa_pkg::ST_Z] = alu_z;
      end
    end

    if (branch) begin
      nxt.pc      = branch_pc & rcfa_pkg::PMEM_MASK;
      nxt.ir      = rcfa_pkg::INSN_NOP;
      nxt.rd_addr = 7'h00;
      nxt.pipe    = rcfa_pkg::PIPE_FLUSH;
    end else begin
      nxt.pc      = (cur.pc + 10'h001) & rcfa_pkg::PMEM_MASK;
      nxt.ir      = PMEM_DATA_IN;
      nxt.rd_addr = resolve(PMEM_DATA_IN[6:0], nxt.fsr);
    end
  end

  // Single state register for the whole core
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cur <= rcfa_pkg::STATE_RESET;
    end else begin
      cur <= nxt;
    end
  end

  // Outputs straight from state flops
  assign PMEM_ADDR_OUT    = cur.pc;
  assign DMEM_RD_ADDR_OUT = cur.rd_addr;
  assign DMEM_WR_ADDR_OUT = cur.wr_addr;
  assign DMEM_WDATA_OUT   = cur.wr_data;
  assign DMEM_WE_OUT      = cur.wr_en;
  assign W_OUT            = cur.w;
  assign FLAGS_OUT        = cur.flags;
  assign EXEC_VALID_OUT   = cur.pipe[0]; // One-hot run bit

endmodule

// ===== shared/rcfa_pkg.sv
package rcfa_pkg;

  // Widths of the core buses
  localparam int PC_W = 10;
  localparam int IW   = 14;
  localparam int DW   = 8;
  localparam int FA_W = 7;

  // Program space size; 1K words, set mask to 10'h1FF for the 512 variant
  localparam logic [9:0]  PMEM_MASK = 10'h3FF;
  localparam logic [9:0]  PC_RESET  = 10'h000;

  // Instruction classes in word bits 13:12
  localparam logic [1:0]  CLS_BYTE = 2'h0;
  localparam logic [1:0]  CLS_RSVD = 2'h1;
  localparam logic [1:0]  CLS_GOTO = 2'h2;
  localparam logic [1:0]  CLS_LIT  = 2'h3;

  // Field positions inside the instruction word
  localparam int CLS_HI  = 13;
  localparam int CLS_LO  = 12;
  localparam int OP_HI   = 11;
  localparam int OP_LO   = 8;
  localparam int DEST_B  = 7;

  // Operation codes in word bits 11:8
  localparam logic [3:0]  OP_MOVWF = 4'h0;
  localparam logic [3:0]  OP_CLR   = 4'h1;
  localparam logic [3:0]  OP_SUB   = 4'h2;
  localparam logic [3:0]  OP_DEC   = 4'h3;
  localparam logic [3:0]  OP_IOR   = 4'h4;
  localparam logic [3:0]  OP_AND   = 4'h5;
  localparam logic [3:0]  OP_XOR   = 4'h6;
  localparam logic [3:0]  OP_ADD   = 4'h7;
  localparam logic [3:0]  OP_MOV   = 4'h8;
  localparam logic [3:0]  OP_COM   = 4'h9;
  localparam logic [3:0]  OP_INC   = 4'hA;
  localparam logic [3:0]  OP_RRF   = 4'hB;
  localparam logic [3:0]  OP_RLF   = 4'hC;
  localparam logic [3:0]  OP_SWAP  = 4'hD;
  localparam logic [3:0]  OP_NOP   = 4'hE;
  localparam logic [3:0]  OP_RSVD  = 4'hF;

  localparam logic [13:0] INSN_NOP = 14'h0E00;

  // Core registers mapped into the data space
  localparam logic [6:0]  ADDR_INDIRECT = 7'h00;
  localparam logic [6:0]  ADDR_PCL      = 7'h01;
  localparam logic [6:0]  ADDR_STATUS   = 7'h02;
  localparam logic [6:0]  ADDR_FSR      = 7'h03;

  // Flag positions in the status register
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;

  localparam logic [7:0]  W_RESET     = 8'h00;
  localparam logic [7:0]  FSR_RESET   = 8'h00;
  localparam logic [2:0]  FLAGS_RESET = 3'h0;

  typedef enum logic [1:0] {
    PIPE_RUN   = 2'b01,
    PIPE_FLUSH = 2'b10
  } rcfa_pipe_e;

  typedef struct packed {
    rcfa_pipe_e  pipe;
    logic [9:0]  pc;
    logic [13:0] ir;
    logic [6:0]  rd_addr;
    logic [7:0]  w;
    logic [2:0]  flags;
    logic [7:0]  fsr;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_en;
  } rcfa_state_s;

  localparam rcfa_state_s STATE_RESET = '{
    pipe:    PIPE_RUN,
    pc:      PC_RESET,
    ir:      INSN_NOP,
    rd_addr: 7'h00,
    w:       W_RESET,
    flags:   FLAGS_RESET,
    fsr:     FSR_RESET,
    wr_addr: 7'h00,
    wr_data: 8'h00,
    wr_en:   1'b0
  };

endpackage

// ===== hdl/rcfa_alu.sv
`timescale 1ns/10ps
module rcfa_alu (
  input  wire logic [3:0] op_in,      // Operation code
  input  wire logic       lit_in,     // Literal class instruction
  input  wire logic [7:0] w_in,       // Working accumulator
  input  wire logic [7:0] b_in,       // File value or literal
  input  wire logic       carry_in,   // Current carry flag
  output logic      [7:0] res_out,    // Result byte
  output logic            c_out,      // Carry or inverted borrow
  output logic            dc_out,     // Half carry or inverted borrow
  output logic            z_out,      // Result is zero
  output logic            upd_c_out,  // Carry flag to be updated
  output logic            upd_dc_out, // Half carry to be updated
  output logic            upd_z_out   // Zero flag to be updated
);

  logic [7:0] add_x;
  logic [7:0] add_y;
  logic       add_ci;
  logic [8:0] sum;
  logic [4:0] nib;

  // Shared adder; subtraction adds the complement plus one
  always_comb begin
    add_x  = w_in;
    add_y  = b_in;
    add_ci = 1'b0;
    case (op_in)
      rcfa_pkg::OP_SUB: begin
        add_x  = b_in;
        add_y  = ~w_in;
        add_ci = 1'b1;
      end
      rcfa_pkg::OP_INC: begin
        add_x  = b_in;
        add_y  = 8'h00;
        add_ci = 1'b1;
      end
      rcfa_pkg::OP_DEC: begin
        add_x  = b_in;
        add_y  = 8'hFF;
        add_ci = 1'b0;
      end
      default: ;
    endcase
  end

  assign sum = {1'b0, add_x} + {1'b0, add_y} + {8'h00, add_ci};
  assign nib = {1'b0, add_x[3:0]} + {1'b0, add_y[3:0]} + {4'h0, add_ci};

  // Result select and flag enables
  always_comb begin
    res_out    = b_in;
    c_out      = carry_in;
    dc_out     = nib[4];
    upd_c_out  = 1'b0;
    upd_dc_out = 1'b0;
    upd_z_out  = 1'b1;
    case (op_in)
      rcfa_pkg::OP_MOVWF: begin
        res_out   = w_in;
        upd_z_out = 1'b0;
      end
      rcfa_pkg::OP_CLR:  res_out = 8'h00;
      rcfa_pkg::OP_ADD, rcfa_pkg::OP_SUB: begin
        res_out    = sum[7:0];
        c_out      = sum[8];
        upd_c_out  = 1'b1;
        upd_dc_out = 1'b1;
      end
      rcfa_pkg::OP_INC, rcfa_pkg::OP_DEC: res_out = sum[7:0];
      rcfa_pkg::OP_IOR:  res_out = w_in | b_in;
      rcfa_pkg::OP_AND:  res_out = w_in & b_in;
      rcfa_pkg::OP_XOR:  res_out = w_in ^ b_in;
      // Literal load leaves flags alone, file move sets zero
      rcfa_pkg::OP_MOV:  upd_z_out = ~lit_in;
      rcfa_pkg::OP_COM:  res_out = ~b_in;
      rcfa_pkg::OP_RRF: begin
        res_out   = {carry_in, b_in[7:1]};
        c_out     = b_in[0];
        upd_c_out = 1'b1;
        upd_z_out = 1'b0;
      end
      rcfa_pkg::OP_RLF: begin
        res_out   = {b_in[6:0], carry_in};
        c_out     = b_in[7];
        upd_c_out = 1'b1;
        upd_z_out = 1'b0;
      end
      rcfa_pkg::OP_SWAP: begin
        res_out   = {b_in[3:0], b_in[7:4]};
        upd_z_out = 1'b0;
      end
      default: upd_z_out = 1'b0;
    endcase
    z_out = (res_out == 8'h00);
  end

endmodule

// ===== dv/rcfa_core_sva.sv
`timescale 1ns/10ps
module rcfa_core_sva (
  input  wire logic       CLK_IN,           // Core clock
  input  wire logic       RST_IN,           // Async reset, active high
  input  wire logic [9:0] PMEM_ADDR_OUT,    // Fetch address
  input  wire logic [6:0] DMEM_WR_ADDR_OUT, // Data write address
  input  wire logic       DMEM_WE_OUT,      // Data write strobe
  input  wire logic [7:0] W_OUT,            // Accumulator value
  input  wire logic [2:0] FLAGS_OUT,        // Zero, half carry, carry
  input  wire logic       EXEC_VALID_OUT    // Execute slot holds work
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  // Flush slot steps: no write for the branch nor for the bubble
  sequence no_write_2;
    !DMEM_WE_OUT ##1 !DMEM_WE_OUT;
  endsequence
  sequence seq_fetch;
    PMEM_ADDR_OUT == $past(PMEM_ADDR_OUT) + 10'h001;
  endsequence

  pc_jump_flush_a: assert property (
    (!$past(RST_IN) && PMEM_ADDR_OUT != $past(PMEM_ADDR_OUT) + 10'h001)
      |-> !EXEC_VALID_OUT)
    else $error("fetch address jumped without a bubble");
  flush_single_a: assert property (
    !EXEC_VALID_OUT |=> EXEC_VALID_OUT)
    else $error("bubble lasted more than one cycle");
  flush_quiet_a: assert property (
    !EXEC_VALID_OUT |=> $stable(W_OUT) && $stable(FLAGS_OUT))
    else $error("bubble changed accumulator or flags");
  flush_no_write_a: assert property (
    !EXEC_VALID_OUT |-> no_write_2)
    else $error("write strobe around a bubble");
  flush_refetch_a: assert property (
    !EXEC_VALID_OUT |=> seq_fetch)
    else $error("fetch did not advance after bubble");
  core_wr_block_a: assert property (
    DMEM_WE_OUT |-> DMEM_WR_ADDR_OUT > 7'h03)
    else $error("core register write reached data memory");
  pc_mask_a: assert property (
    (PMEM_ADDR_OUT & ~rcfa_pkg::PMEM_MASK) == 10'h000)
    else $error("fetch address beyond program space");
  zero_flag_a: assert property (
    ($changed(W_OUT) && $changed(FLAGS_OUT[2]))
      |-> FLAGS_OUT[2] == (W_OUT == 8'h00))
    else $error("zero flag disagrees with accumulator");
endmodule

bind rcfa_core rcfa_core_sva rcfa_core_sva_i (
  .CLK_IN           (CLK_IN),
  .RST_IN           (RST_IN),
  .PMEM_ADDR_OUT    (PMEM_ADDR_OUT),
  .DMEM_WR_ADDR_OUT (DMEM_WR_ADDR_OUT),
  .DMEM_WE_OUT      (DMEM_WE_OUT),
  .W_OUT            (W_OUT),
  .FLAGS_OUT        (FLAGS_OUT),
  .EXEC_VALID_OUT   (EXEC_VALID_OUT)
);

// ===== dv/rcfa_mem_model.sv
`timescale 1ns/10ps
module rcfa_mem_model (
  input  wire logic        clk_in,        // Core clock
  input  wire logic [9:0]  pmem_addr_in,  // Fetch address
  output logic      [13:0] pmem_data_out, // Word at fetch address
  input  wire logic [6:0]  rd_addr_in,    // Data read address
  output logic      [7:0]  rdata_out,     // Byte at read address
  input  wire logic [6:0]  wr_addr_in,    // Data write address
  input  wire logic [7:0]  wdata_in,      // Data write byte
  input  wire logic        we_in          // Data write strobe
);
  logic [13:0] prog_mem [1024];
  logic [7:0]  data_mem [128];

  // Marker value so a read of an unwritten byte is never mistaken for 0
  initial begin
    foreach (data_mem[i]) begin
      data_mem[i] = 8'hA5;
    end
  end

  // whole word each cycle, 1K deep
  assign pmem_data_out = prog_mem[pmem_addr_in];
  assign rdata_out = data_mem[rd_addr_in];

  // Write lands at the edge ending the strobe cycle
  always @(posedge clk_in) begin
    if (we_in) begin
      data_mem[wr_addr_in] <= wdata_in;
    end
  end
endmodule

// ===== dv/rcfa_core_tb_top.sv
`timescale 1ns/10ps
module rcfa_core_tb_top;
  logic        clk_in;
  logic        rst_in;
  logic [9:0]  pmem_addr;
  logic [13:0] pmem_data;
  logic [6:0]  rd_addr;
  logic [7:0]  rdata;
  logic [6:0]  wr_addr;
  logic [7:0]  wdata;
  logic        we;
  logic [7:0]  w_val;
  logic [2:0]  flags;
  logic        exec_valid;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  rcfa_core rcfa_core_i (
    .CLK_IN           (clk_in),
    .RST_IN           (rst_in),
    .PMEM_ADDR_OUT    (pmem_addr),
    .PMEM_DATA_IN     (pmem_data),
    .DMEM_RD_ADDR_OUT (rd_addr),
    .DMEM_RDATA_IN    (rdata),
    .DMEM_WR_ADDR_OUT (wr_addr),
    .DMEM_WDATA_OUT   (wdata),
    .DMEM_WE_OUT      (we),
    .W_OUT            (w_val),
    .FLAGS_OUT        (flags),
    .EXEC_VALID_OUT   (exec_valid)
  );

  rcfa_mem_model rcfa_mem_model_i (
    .clk_in        (clk_in),
    .pmem_addr_in  (pmem_addr),
    .pmem_data_out (pmem_data),
    .rd_addr_in    (rd_addr),
    .rdata_out     (rdata),
    .wr_addr_in    (wr_addr),
    .wdata_in      (wdata),
    .we_in         (we)
  );

  // Free running core clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Hang guard: seven short programs need a few hundred cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [2:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  // Instruction word builders
  function automatic logic [13:0] lit_w(logic [3:0] op, logic [7:0] k);
    return {rcfa_pkg::CLS_LIT, op, k};
  endfunction
  function automatic logic [13:0] byt_w(logic [3:0] op, logic d,
                                        logic [6:0] f);
    return {rcfa_pkg::CLS_BYTE, op, d, f};
  endfunction
  function automatic logic [13:0] jmp_w(logic [9:0] t);
    return {rcfa_pkg::CLS_GOTO, 2'h0, t};
  endfunction

  // Core held in reset while a fresh program is loaded
  task automatic start_prog();
    @(negedge clk_in);
    rst_in = 1'b1;
    foreach (rcfa_mem_model_i.prog_mem[i]) begin
      rcfa_mem_model_i.prog_mem[i] = rcfa_pkg::INSN_NOP;
    end
  endtask
  task automatic put(input int a, input logic [13:0] w);
    rcfa_mem_model_i.prog_mem[a] = w;
  endtask
  task automatic release_core();
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
  endtask
  task automatic run_prog();
    release_core();
    repeat (40) @(negedge clk_in);
  endtask

  task automatic arith_add_sub();
    start_prog();
    put(0, lit_w(rcfa_pkg::OP_MOV, 8'h0F));
    put(1, lit_w(rcfa_pkg::OP_ADD, 8'h01));
    put(2, jmp_w(10'h002));
    run_prog();
    chk_byte(w_val, 8'h10, "add result");
    chk_flags(flags, 3'h2, "add flags");
    start_prog();
    put(0, lit_w(rcfa_pkg::OP_MOV, 8'h05));
    put(1, lit_w(rcfa_pkg::OP_SUB, 8'h05));
    put(2, jmp_w(10'h002));
    run_prog();
    chk_byte(w_val, 8'h00, "sub zero");
    chk_flags(flags, 3'h7, "sub zero flags");
    start_prog();
    put(0, lit_w(rcfa_pkg::OP_MOV, 8'h01));
    put(1, lit_w(rcfa_pkg::OP_SUB, 8'h10));
    put(2, jmp_w(10'h002));
    run_prog();
    chk_byte(w_val, 8'h0F, "sub borrow");
    chk_flags(flags, 3'h1, "sub nibble borrow");
  endtask

  task automatic logic_shift();
    start_prog();
    put(0, lit_w(rcfa_pkg::OP_MOV, 8'h81));
    put(1, byt_w(rcfa_pkg::OP_MOVWF, 1'b1, 7'h21));
    put(2, byt_w(rcfa_pkg::OP_RLF, 1'b0, 7'h21));
    put(3, byt_w(rcfa_pkg::OP_RRF, 1'b1, 7'h21));
    put(4, byt_w(rcfa_pkg::OP_DEC, 1'b0, 7'h21));
    put(5, lit_w(rcfa_pkg::OP_XOR, 8'hFF));
    put(6, lit_w(rcfa_pkg::OP_AND, 8'h70));
    put(7, lit_w(rcfa_pkg::OP_IOR, 8'h01));
    put(8, jmp_w(10'h008));
    run_prog();
    chk_byte(rcfa_mem_model_i.data_mem[8'h21], 8'hC0, "rotate");
    chk_byte(w_val, 8'h41, "logic chain");
    chk_flags(flags, 3'h1, "shift carry");
  endtask

  task automatic file_ops();
    start_prog();
    put(0, lit_w(rcfa_pkg::OP_MOV, 8'h3C));
    put(1, byt_w(rcfa_pkg::OP_MOVWF, 1'b1, 7'h20));
    put(2, byt_w(rcfa_pkg::OP_INC, 1'b1, 7'h20));
    put(3, byt_w(rcfa_pkg::OP_COM, 1'b0, 7'h20));
    put(4, lit_w(rcfa_pkg::OP_MOV, 8'h20));
    put(5, byt_w(rcfa_pkg::OP_MOVWF, 1'b1, rcfa_pkg::ADDR_FSR));
    put(6, byt_w(rcfa_pkg::OP_SWAP, 1'b1, rcfa_pkg::ADDR_INDIRECT));
    put(7, byt_w(rcfa_pkg::OP_CLR, 1'b1, 7'h23));
    put(8, jmp_w(10'h008));
    run_prog();
    chk_byte(rcfa_mem_model_i.data_mem[8'h20], 8'hD3, "indirect");
    chk_byte(rcfa_mem_model_i.data_mem[8'h23], 8'h00, "clear");
    chk_byte(w_val, 8'h20, "pointer value");
    chk_flags(flags, 3'h4, "clear zero");
  endtask

  task automatic branch_timing();
    start_prog();
    put(0, lit_w(rcfa_pkg::OP_MOV, 8'h01));
    put(1, jmp_w(10'h004));
    put(2, lit_w(rcfa_pkg::OP_MOV, 8'h55));
    put(3, lit_w(rcfa_pkg::OP_MOV, 8'h55));
    put(4, lit_w(rcfa_pkg::OP_ADD, 8'h01));
    put(5, jmp_w(10'h005));
    release_core();
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk_byte(w_val, 8'h01, "one cycle op");
    @(negedge clk_in);
    chk_byte({7'h00, exec_valid}, 8'h00, "bubble slot");
    @(negedge clk_in);
    chk_byte(w_val, 8'h01, "dropped word");
    chk_byte({7'h00, exec_valid}, 8'h01, "after bubble");
    @(negedge clk_in);
    chk_byte(w_val, 8'h02, "target op");
    repeat (20) @(negedge clk_in);
  endtask

  task automatic core_regs();
    start_prog();
    put(1, byt_w(rcfa_pkg::OP_MOV, 1'b0, rcfa_pkg::ADDR_PCL));
    put(2, byt_w(rcfa_pkg::OP_MOVWF, 1'b1, 7'h22));
    put(3, lit_w(rcfa_pkg::OP_MOV, 8'h06));
    put(4, byt_w(rcfa_pkg::OP_MOVWF, 1'b1, rcfa_pkg::ADDR_PCL));
    put(5, lit_w(rcfa_pkg::OP_MOV, 8'hEE));
    put(6, jmp_w(10'h006));
    run_prog();
    chk_byte(rcfa_mem_model_i.data_mem[8'h22], 8'h01, "pc read");
    chk_byte(rcfa_mem_model_i.data_mem[8'h01], 8'hA5, "pc slot");
    chk_byte(w_val, 8'h06, "pc write jump");
  endtask

  // Main sequence
  initial begin
    rst_in = 1'b1;
    arith_add_sub();
    logic_shift();
    file_ops();
    branch_timing();
    core_regs();
    tally_and_finish();
  end
endmodule
